// File: include/vctc_pkg.sv
// Purpose: Constants and carriers for the coarse tune configuration block
// Assumes: One 8-bit register reached through a simple parallel write strobe, read back without a strobe
// Notes:
package vctc_pkg;
   localparam int unsigned CLK_HZ = 32'h017d7840;
   localparam int REG_W = 8;
   localparam int TRIM_LSB = 0;
   localparam int TRIM_W = 2;
   localparam int UNLOCK_BIT = 2;
   localparam int DLY_LSB = 4;
   localparam int DLY_W = 3;
   localparam int CNT_W = 16;
   localparam logic [DLY_W-1:0] DLY_RST = 3'h2;
   localparam logic [TRIM_W-1:0] TRIM_RST = 2'h1;
   localparam logic UNLOCK_RST = 1'b1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] DLY_C0 = 16'h04b0;
   localparam logic [CNT_W-1:0] DLY_C1 = 16'h09c4;
   localparam logic [CNT_W-1:0] DLY_C2 = 16'h0fa0;
   localparam logic [CNT_W-1:0] DLY_C3 = 16'h1900;
   localparam logic [CNT_W-1:0] DLY_C4 = 16'h3d09;
   localparam logic [CNT_W-1:0] DLY_C5 = 16'h6e23;
   localparam logic [CNT_W-1:0] DLY_C6 = 16'h8647;

   typedef struct packed {
      logic [DLY_W-1:0] dly_sel;
      logic unlock;
      logic [TRIM_W-1:0] trim;
   } vctc_cfg_t;

   typedef enum logic [1:0] {
      VCTC_IDLE = 2'b00,
      VCTC_WAIT = 2'b01,
      VCTC_SRCH = 2'b10
   } vctc_state_t;
endpackage

// File: hdl/vctc_top.sv
// Purpose: Coarse tune configuration register and calibration start-up delay
// Assumes: All inputs synchronous to clk_sys; nvm_load pulses once at start-up
// Notes: Delay counts are cycles of clk_sys as the reference clock
`timescale 1ns/1ns
module vctc_top #(
   parameter logic [15:0] DLY_SCALE_DIV = 16'h0001
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic nvm_load,
   input wire logic [1:0] nvm_trim,
   input wire logic nvm_unlock,
   input wire logic trim_cal_en,
   input wire logic [1:0] cal_trim,
   input wire logic cal_start,
   output logic search_go,
   output logic [1:0] vco_trim_out
);
   vctc_pkg::vctc_cfg_t cfg_r;
   vctc_pkg::vctc_state_t state_r;
   logic [vctc_pkg::CNT_W-1:0] cnt_r;
   logic [vctc_pkg::CNT_W-1:0] dly_cycles;
   logic [vctc_pkg::TRIM_W-1:0] wr_trim;
   logic wr_unlock;
   logic [vctc_pkg::DLY_W-1:0] wr_dly;
   logic [vctc_pkg::REG_W-1:0] rd_img;

   // Write data fields and readback image
   assign wr_trim = reg_wdata[vctc_pkg::TRIM_LSB +: vctc_pkg::TRIM_W];
   assign wr_unlock = reg_wdata[vctc_pkg::UNLOCK_BIT];
   assign wr_dly = reg_wdata[vctc_pkg::DLY_LSB +: vctc_pkg::DLY_W];
   assign rd_img = {1'b0, cfg_r.dly_sel, 1'b0, cfg_r.unlock, cfg_r.trim};

   // Select delay; code 7 maps to the longest
   always_comb begin
      unique case (cfg_r.dly_sel)
         3'h0: dly_cycles = vctc_pkg::DLY_C0;
         3'h1: dly_cycles = vctc_pkg::DLY_C1;
         3'h2: dly_cycles = vctc_pkg::DLY_C2;
         3'h3: dly_cycles = vctc_pkg::DLY_C3;
         3'h4: dly_cycles = vctc_pkg::DLY_C4;
         3'h5: dly_cycles = vctc_pkg::DLY_C5;
         3'h6: dly_cycles = vctc_pkg::DLY_C6;
         default: dly_cycles = vctc_pkg::DLY_C6;
      endcase
   end

   // Register writes and factory load
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r.dly_sel <= vctc_pkg::DLY_RST;
         cfg_r.unlock <= vctc_pkg::UNLOCK_RST;
         cfg_r.trim <= vctc_pkg::TRIM_RST;
      end else if (nvm_load) begin
         cfg_r.trim <= nvm_trim;
         cfg_r.unlock <= nvm_unlock;
      end else if (reg_wr) begin
         cfg_r.dly_sel <= wr_dly;
         cfg_r.unlock <= wr_unlock;
         if (cfg_r.unlock) begin
            cfg_r.trim <= wr_trim;
         end
      end
   end

   // Readback, reserved bits zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rd_img;
      end
   end

   // Applied tuning
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vco_trim_out <= vctc_pkg::TRIM_RST;
      end else begin
         vco_trim_out <= trim_cal_en ? cal_trim : cfg_r.trim;
      end
   end

   // Start-up delay sequencer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= vctc_pkg::VCTC_IDLE;
         cnt_r <= vctc_pkg::CNT_ZERO;
         search_go <= 1'b0;
      end else begin
         search_go <= 1'b0;
         unique case (state_r)
            vctc_pkg::VCTC_IDLE: begin
               if (cal_start) begin
                  cnt_r <= dly_cycles;
                  state_r <= vctc_pkg::VCTC_WAIT;
               end
            end
            vctc_pkg::VCTC_WAIT: begin
               if (cnt_r <= DLY_SCALE_DIV) begin
                  state_r <= vctc_pkg::VCTC_SRCH;
                  search_go <= 1'b1;
               end else begin
                  cnt_r <= cnt_r - DLY_SCALE_DIV;
               end
            end
            vctc_pkg::VCTC_SRCH: begin
               if (!cal_start) begin
                  state_r <= vctc_pkg::VCTC_IDLE;
               end
            end
            default: state_r <= vctc_pkg::VCTC_IDLE;
         endcase
      end
   end

   property p_trim_lock;
      @(posedge clk_sys) disable iff (!rst_n)
         (reg_wr && !nvm_load && !cfg_r.unlock) |=> $stable(cfg_r.trim);
   endproperty
   a_trim_lock: assert property (p_trim_lock) else $error("Trim changed while locked");

   property p_trim_wr;
      @(posedge clk_sys) disable iff (!rst_n)
         (reg_wr && !nvm_load && cfg_r.unlock) |=> (cfg_r.trim == $past(wr_trim));
   endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("Unlocked trim write lost");

   property p_cal_src;
      @(posedge clk_sys) disable iff (!rst_n)
         trim_cal_en |=> (vco_trim_out == $past(cal_trim));
   endproperty
   a_cal_src: assert property (p_cal_src) else $error("Trim not from calibration");

   property p_nvm;
      @(posedge clk_sys) disable iff (!rst_n)
         nvm_load |=> (cfg_r.unlock == $past(nvm_unlock)) && (cfg_r.trim == $past(nvm_trim));
   endproperty
   a_nvm: assert property (p_nvm) else $error("Factory load missed");

   sequence s_start;
      state_r == vctc_pkg::VCTC_IDLE && cal_start;
   endsequence
   property p_no_early;
      @(posedge clk_sys) disable iff (!rst_n)
         s_start |=> !search_go [*8];
   endproperty
   a_no_early: assert property (p_no_early) else $error("Search started early");

   property p_code7;
      @(posedge clk_sys) disable iff (!rst_n)
         (cfg_r.dly_sel == 3'h7) |-> (dly_cycles == vctc_pkg::DLY_C6);
   endproperty
   a_code7: assert property (p_code7) else $error("Code 7 delay wrong");

   property p_manual;
      @(posedge clk_sys) disable iff (!rst_n)
         !trim_cal_en |=> (vco_trim_out == $past(cfg_r.trim));
   endproperty
   a_manual: assert property (p_manual) else $error("Manual trim not applied");

   property p_go_state;
      @(posedge clk_sys) disable iff (!rst_n)
         search_go |-> (state_r == vctc_pkg::VCTC_SRCH) &&
            ($past(state_r) == vctc_pkg::VCTC_WAIT);
   endproperty
   a_go_state: assert property (p_go_state) else $error("Search pulse out of sequence");

   sequence s_wait_more;
      state_r == vctc_pkg::VCTC_WAIT && cnt_r > DLY_SCALE_DIV;
   endsequence

   sequence s_wait_end;
      state_r == vctc_pkg::VCTC_WAIT && cnt_r <= DLY_SCALE_DIV;
   endsequence

   sequence s_held;
      state_r == vctc_pkg::VCTC_SRCH && cal_start;
   endsequence

   property p_dly_load;
      @(posedge clk_sys) disable iff (!rst_n)
         s_start |=> (state_r == vctc_pkg::VCTC_WAIT) && (cnt_r == $past(dly_cycles));
   endproperty
   a_dly_load: assert property (p_dly_load) else $error("Delay count not loaded");

   property p_count;
      @(posedge clk_sys) disable iff (!rst_n)
         s_wait_more |=> (state_r == vctc_pkg::VCTC_WAIT) &&
            (cnt_r == $past(cnt_r) - DLY_SCALE_DIV);
   endproperty
   a_count: assert property (p_count) else $error("Delay count step wrong");

   property p_go_end;
      @(posedge clk_sys) disable iff (!rst_n)
         s_wait_end |=> search_go && (state_r == vctc_pkg::VCTC_SRCH);
   endproperty
   a_go_end: assert property (p_go_end) else $error("Search missed at count end");

   property p_go_pulse;
      @(posedge clk_sys) disable iff (!rst_n)
         search_go |=> !search_go;
   endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("Search pulse too long");

   property p_refuse;
      @(posedge clk_sys) disable iff (!rst_n)
         s_held |=> (state_r == vctc_pkg::VCTC_SRCH) && !search_go;
   endproperty
   a_refuse: assert property (p_refuse) else $error("Held start restarted");

   property p_idle;
      @(posedge clk_sys) disable iff (!rst_n)
         (state_r == vctc_pkg::VCTC_IDLE && !cal_start) |=>
            (state_r == vctc_pkg::VCTC_IDLE) && !search_go;
   endproperty
   a_idle: assert property (p_idle) else $error("Sequencer left idle unasked");

   property p_unlock_wr;
      @(posedge clk_sys) disable iff (!rst_n)
         (reg_wr && !nvm_load) |=> (cfg_r.unlock == $past(wr_unlock));
   endproperty
   a_unlock_wr: assert property (p_unlock_wr) else $error("Unlock write lost");

   property p_dly_wr;
      @(posedge clk_sys) disable iff (!rst_n)
         (reg_wr && !nvm_load) |=> (cfg_r.dly_sel == $past(wr_dly));
   endproperty
   a_dly_wr: assert property (p_dly_wr) else $error("Delay code write lost");

   property p_nvm_dly;
      @(posedge clk_sys) disable iff (!rst_n)
         nvm_load |=> $stable(cfg_r.dly_sel);
   endproperty
   a_nvm_dly: assert property (p_nvm_dly) else $error("Factory load hit delay code");

   property p_trim_hold;
      @(posedge clk_sys) disable iff (!rst_n)
         (!reg_wr && !nvm_load) |=> $stable(cfg_r.trim);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("Trim changed with no write");

   property p_rdata;
      @(posedge clk_sys) disable iff (!rst_n)
         1'b1 |=> (reg_rdata == $past(rd_img));
   endproperty
   a_rdata: assert property (p_rdata) else $error("Readback does not follow register");
endmodule

// File: test/vctc_top_bench.sv
// Purpose: Self-checking bench for the coarse tune configuration block
// Assumes: Delays scaled by DLY_SCALE_DIV = 100
// Notes: Inputs change at the falling edge
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module vctc_top_bench;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic nvm_load = 1'b0;
   logic [1:0] nvm_trim = 2'h1;
   logic nvm_unlock = 1'b0;
   logic trim_cal_en = 1'b0;
   logic [1:0] cal_trim = 2'h3;
   logic cal_start = 1'b0;
   logic search_go;
   logic [1:0] vco_trim_out;
   int miscompares = 0;
   int compares = 0;
   typedef struct packed { logic [7:0] wd; logic [7:0] rd; } vctc_row_t;
   vctc_row_t rows [5] = '{'{8'h07, 8'h07}, '{8'h00, 8'h00}, '{8'h03, 8'h00},
      '{8'h77, 8'h74}, '{8'hfa, 8'h72}};
   always #20 clk_sys = ~clk_sys;
   vctc_top #(.DLY_SCALE_DIV(16'h0064)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .nvm_load(nvm_load), .nvm_trim(nvm_trim), .nvm_unlock(nvm_unlock),
      .trim_cal_en(trim_cal_en), .cal_trim(cal_trim), .cal_start(cal_start),
      .search_go(search_go), .vco_trim_out(vco_trim_out));
   task automatic wr(input logic [7:0] d);
      reg_wr = 1'b1;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic run_dly(input logic [2:0] code, input int n);
      int c;
      c = 0;
      wr({1'b0, code, 4'h0});
      cal_start = 1'b1;
      while (search_go !== 1'b1 && c < 1000) begin
         @(negedge clk_sys);
         c++;
      end
      cal_start = 1'b0;
      `CHK("delay cycles", (n + 99) / 100 + 1, c)
      @(negedge clk_sys);
      `CHK("go pulse", 1'b0, search_go)
      $display("test delay code %0d done", code);
   endtask
   task automatic final_report();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_sys);
      miscompares++;
      final_report();
   end
   initial begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      `CHK("reset rdata", 8'h25, reg_rdata)
      `CHK("reset trim", 2'h1, vco_trim_out)
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].wd);
         `CHK("rdata", rows[i].rd, reg_rdata)
         `CHK("trim out", rows[i].rd[1:0], vco_trim_out)
      end
      $display("test table done");
      trim_cal_en = 1'b1;
      repeat (2) @(negedge clk_sys);
      `CHK("cal trim", 2'h3, vco_trim_out)
      trim_cal_en = 1'b0;
      $display("test cal trim done");
      wr(8'h74);
      `CHK("unlock set", 8'h76, reg_rdata)
      nvm_load = 1'b1;
      reg_wr = 1'b1;
      reg_wdata = 8'h05;
      @(negedge clk_sys);
      nvm_load = 1'b0;
      reg_wr = 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK("nvm rdata", 8'h71, reg_rdata)
      wr(8'h73);
      `CHK("locked trim", 8'h71, reg_rdata)
      $display("test nvm done");
      run_dly(3'h0, 1200);
      run_dly(3'h1, 2500);
      run_dly(3'h2, 4000);
      run_dly(3'h3, 6400);
      run_dly(3'h4, 15625);
      run_dly(3'h5, 28195);
      run_dly(3'h6, 34375);
      run_dly(3'h7, 34375);
      begin : awkward
         int seen;
         seen = 0;
         wr(8'h00);
         cal_start = 1'b1;
         repeat (40) begin
            @(negedge clk_sys);
            if (search_go === 1'b1) begin
               seen++;
            end
         end
         cal_start = 1'b0;
         `CHK("one search per start", 1, seen)
         $display("test held start done");
         wr(8'h60);
         cal_start = 1'b1;
         repeat (5) @(negedge clk_sys);
         rst_n = 1'b0;
         cal_start = 1'b0;
         @(negedge clk_sys);
         `CHK("search in reset", 1'b0, search_go)
         rst_n = 1'b1;
         repeat (2) @(negedge clk_sys);
         `CHK("rerun rdata", 8'h25, reg_rdata)
         seen = 0;
         repeat (60) begin
            @(negedge clk_sys);
            if (search_go === 1'b1) begin
               seen++;
            end
         end
         `CHK("no search after reset", 0, seen)
         $display("test mid reset done");
      end
      final_report();
   end
endmodule
